// >>> bench/spi_host_model.sv
// Host controller model driving the SPI link of the control port
`timescale 1ns/100ps
module spi_host_model (
    input  logic       clk,
    input  logic       sdio_w,
    input  logic       sdo_w,
    output logic       sclk,
    output logic       cs_n,
    output logic       h_d,
    output logic       h_oe,
    output logic [7:0] rd_byte,
    output logic       rd_stb
);
    logic lsb;
    logic uni;
    initial begin
        {sclk, cs_n, h_d, h_oe, rd_stb, lsb, uni} = 7'b0100000;
        rd_byte = 8'h00;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Read bit taken just before the next rise, where it is settled
    task automatic shift(input [15:0] v, input int nb, input bit rd,
                         output [15:0] r);
        int k;
        r = 16'h0000;
        for (int i = 0; i < nb; i++) begin
            k = lsb ? i : nb - 1 - i;
            h_d = v[k];
            h_oe = !rd;
            wait_clk(4);
            r[k] = uni ? sdo_w : sdio_w;
            sclk = 1'b1;
            wait_clk(4);
            sclk = 1'b0;
        end
    endtask
    task automatic cycle(input [15:0] ins, input int n, input [31:0] wd,
                         input bit st, input int x);
        logic [15:0] r;
        cs_n = 1'b0;
        wait_clk(4);
        shift(ins, 16, 1'b0, r);
        for (int b = 0; b < n; b++) begin
            if (st) begin
                cs_n = 1'b1;
                wait_clk(8);
                cs_n = 1'b0;
                wait_clk(4);
            end
            shift({8'h00, wd[8*b +: 8]}, 8, ins[15], r);
            if (ins[15]) begin
                rd_byte = r[7:0];
                rd_stb = 1'b1;
                wait_clk(1);
                rd_stb = 1'b0;
            end
        end
        if (x > 0) shift(wd[15:0], x, 1'b0, r);
        wait_clk(4);
        cs_n = 1'b1;
        h_oe = 1'b0;
        wait_clk(8);
    endtask
endmodule // spi_host_model

// >>> bench/spi_port_chk.sv
// Assertion checker for the SPI serial control port
`timescale 1ns/100ps
module spi_port_chk (
    input logic clk,
    input logic arst_n,
    input logic sclk,
    input logic cs_n,
    input logic sdio_out,
    input logic sdio_oe,
    input logic sdo_out,
    input logic sdo_oe,
    input logic nv_busy,
    input logic twi_addr_ack,
    input logic update_pulse,
    input logic lsb_first,
    input logic unidir_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire oe_any = sdio_oe | sdo_oe;

    property p_idle_release; cs_n [*6] |-> !oe_any; endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data pin driven while deselected");
    property p_bidir_quiet; unidir_mode |-> !sdio_oe; endproperty
    a_bidir_quiet: assert property (p_bidir_quiet)
        else $error("shared pin driven in split mode");
    property p_unidir_quiet; !unidir_mode |-> !sdo_oe; endproperty
    a_unidir_quiet: assert property (p_unidir_quiet)
        else $error("output pin driven in shared mode");
    property p_pins_agree; oe_any |-> sdo_out == sdio_out; endproperty
    a_pins_agree: assert property (p_pins_agree)
        else $error("readback pins disagree");
    property p_update_single; update_pulse |=> !update_pulse; endproperty
    a_update_single: assert property (p_update_single)
        else $error("update pulse longer than one cycle");
    property p_ack; 1'b1 |=> twi_addr_ack == !$past(nv_busy); endproperty
    a_ack: assert property (p_ack)
        else $error("address answer does not follow busy");
    property p_busy_hold; nv_busy [*4] |-> !update_pulse; endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("update taken while store busy");
    property p_order_quiet; $changed(lsb_first) |-> !oe_any; endproperty
    a_order_quiet: assert property (p_order_quiet)
        else $error("bit order changed during readback");
    property p_oe_late; $rose(oe_any) |-> $past(cs_n, 8) == 1'b0; endproperty
    a_oe_late: assert property (p_oe_late)
        else $error("readback before instruction complete");
endmodule // spi_port_chk

bind serial_control_port spi_port_chk i_chk (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .nv_busy(nv_busy), .twi_addr_ack(twi_addr_ack),
    .update_pulse(update_pulse), .lsb_first(lsb_first),
    .unidir_mode(unidir_mode)
);

// >>> bench/tb.sv
// Self-checking bench for the SPI serial control port
`timescale 1ns/100ps
module tb;
    logic        clk;
    logic        arst_n;
    logic        nv_busy;
    logic        flip;
    logic        sclk, cs_n, h_d, h_oe, rd_stb;
    logic        sdio_out, sdio_oe, sdo_out, sdo_oe, upd;
    logic        ack_o, lsb_o, uni_o;
    logic [7:0]  rd_byte;
    logic [7:0]  exp_q[$];
    logic [31:0] lfsr;
    int          fail_count;
    int          check_count;
    int          upd_seen;
    // Released lines toggle so a stale value never reads as good
    wire         sdio_w = sdio_oe ? sdio_out : h_oe ? h_d : flip;
    wire         sdo_w  = sdo_oe ? sdo_out : flip;

    serial_control_port i_dut (
        .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
        .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .nv_busy(nv_busy),
        .twi_addr_ack(ack_o), .update_pulse(upd), .lsb_first(lsb_o),
        .unidir_mode(uni_o));
    spi_host_model i_host (
        .clk(clk), .sdio_w(sdio_w), .sdo_w(sdo_w), .sclk(sclk),
        .cs_n(cs_n), .h_d(h_d), .h_oe(h_oe), .rd_byte(rd_byte),
        .rd_stb(rd_stb));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(negedge clk) flip <= ~flip;

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    always @(posedge clk) begin
        if (upd === 1'b1) upd_seen++;
        if (rd_stb === 1'b1) begin
            // Unexpected byte: compare against unknown so it counts
            if (exp_q.size() == 0) exp_q.push_back(8'hXX);
            chk("read byte", exp_q.pop_front(), rd_byte);
        end
    end

    function automatic [31:0] nxt(input [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input [12:0] a, input [1:0] len, input int n,
                      input [31:0] d, input int x);
        bit st;
        // Stalling a stream would end it, so only short cycles stall
        st = (n == 3) && (len != 2'b11);
        i_host.cycle({1'b0, len, a}, n, d, st, x);
    endtask
    task automatic rd(input [12:0] a, input [1:0] len, input int n,
                      input [31:0] e);
        for (int b = 0; b < n; b++) exp_q.push_back(e[8*b +: 8]);
        i_host.cycle({1'b1, len, a}, n, 32'h0, 1'b0, 0);
    endtask
    task automatic stop_test();
        chk("pending reads", 8'h00, 8'(exp_q.size()));
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        nv_busy = 1'b0;
        flip = 1'b0;
        lfsr = 32'h7DA5158B;
        fail_count = 0;
        check_count = 0;
        upd_seen = 0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        rd(13'h000, 2'b00, 1, 32'h18);
        wr(13'h012, 2'b10, 3, 32'hC3B2A1, 0);
        for (int c = 0; c < 3; c++)
            rd(13'h012, c[1:0], c + 1, 32'hC3B2A1);
        wr(13'h012, 2'b00, 0, 32'h5, 3);
        rd(13'h012, 2'b00, 1, 32'hA1);
        wr(13'h004, 2'b00, 1, 32'h01, 0);
        rd(13'h012, 2'b00, 1, 32'h00);
        wr(13'h232, 2'b00, 1, 32'h01, 0);
        rd(13'h012, 2'b10, 3, 32'hC3B2A1);
        rd(13'h001, 2'b11, 3, 32'h001800);
        wr(13'h000, 2'b00, 1, 32'h5A, 0);
        chk("bit order", 8'h01, {7'h00, lsb_o});
        i_host.lsb = 1'b1;
        lfsr = nxt(nxt(lfsr));
        wr(13'h230, 2'b11, 3, {16'h01, lfsr[15:0]}, 0);
        rd(13'h230, 2'b01, 2, lfsr);
        wr(13'h000, 2'b00, 1, 32'hDB, 0);
        chk("split mode", 8'h01, {7'h00, uni_o});
        i_host.uni = 1'b1;
        rd(13'h000, 2'b00, 1, 32'hDB);
        nv_busy = 1'b1;
        wr(13'h012, 2'b00, 1, 32'hEE, 0);
        chk("address answer", 8'h00, {7'h00, ack_o});
        rd(13'hB00, 2'b00, 1, 32'h01);
        rd(13'h012, 2'b00, 1, 32'h00);
        nv_busy = 1'b0;
        wr(13'h232, 2'b00, 1, 32'h01, 0);
        chk("address answer", 8'h01, {7'h00, ack_o});
        rd(13'h012, 2'b00, 1, 32'hA1);
        chk("update pulses", 8'h03, 8'(upd_seen));
        stop_test();
    end
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
endmodule // tb

// >>> logic/pin_sync.v
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module pin_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk,
    input  wire arst_n,
    input  wire pin_in,
    output reg  level,
    output reg  rise,
    output reg  fall
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // A change counts only once stages two and three agree
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r  <= RST_VAL;
            s2_r  <= RST_VAL;
            s3_r  <= RST_VAL;
            level <= RST_VAL;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else begin
            s1_r  <= pin_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            rise  <= (s2_r == s3_r) && s3_r && !level;
            fall  <= (s2_r == s3_r) && !s3_r && level;
            if (s2_r == s3_r)
                level <= s3_r;
        end
    end
endmodule // pin_sync

// >>> logic/serial_control_port.v
// SPI serial control port with buffer and active register banks
`timescale 1ns/100ps
`include "spi_port_defines.vh"
module serial_control_port (
    input  wire clk,
    input  wire arst_n,
    input  wire sclk,
    input  wire cs_n,
    input  wire sdio_in,
    output reg  sdio_out,
    output wire sdio_oe,
    output reg  sdo_out,
    output wire sdo_oe,
    input  wire nv_busy,
    output reg  twi_addr_ack,
    output reg  update_pulse,
    output wire lsb_first,
    output wire unidir_mode
);
    localparam [1:0] ST_INSTR = 2'h0;
    localparam [1:0] ST_DATA  = 2'h1;
    localparam [1:0] ST_DONE  = 2'h2;

    wire        sclk_rise;
    wire        cs_high;
    wire        cs_rise;
    wire        sdio_lvl;

    reg  [1:0]  state_r;
    reg  [3:0]  bit_cnt_r;
    reg  [1:0]  bytes_left_r;
    reg         stream_r;
    reg         rd_r;
    reg  [12:0] addr_r;
    reg  [15:0] sh_r;
    reg  [7:0]  tx_r;
    reg         wr_stb_r;
    reg  [12:0] wr_addr_r;
    reg  [7:0]  wr_data_r;
    reg  [7:0]  cfg_r;
    reg         bank_sel_r;

    reg  [7:0]  buf_mem [0:`REG_COUNT-1];
    reg  [7:0]  act_mem [0:`REG_COUNT-1];

    reg  [15:0] sh_nxt;
    reg  [7:0]  rx_byte;
    reg  [12:0] addr_nxt;
    reg  [12:0] rd_addr;
    reg  [7:0]  rd_byte;
    reg  [7:0]  tx_nxt;
    reg         last_byte;
    integer     i;

    pin_sync #(.RST_VAL(1'b0)) u_sclk (
        .clk    (clk),
        .arst_n (arst_n),
        .pin_in (sclk),
        .level  (),
        .rise   (sclk_rise),
        .fall   ()
    );

    pin_sync #(.RST_VAL(1'b1)) u_cs (
        .clk    (clk),
        .arst_n (arst_n),
        .pin_in (cs_n),
        .level  (cs_high),
        .rise   (cs_rise),
        .fall   ()
    );

    pin_sync #(.RST_VAL(1'b0)) u_sdio (
        .clk    (clk),
        .arst_n (arst_n),
        .pin_in (sdio_in),
        .level  (sdio_lvl),
        .rise   (),
        .fall   ()
    );

    assign lsb_first   = cfg_r[`CFG_LSB_HI] & cfg_r[`CFG_LSB_LO]; // RULE_15
    assign unidir_mode = cfg_r[`CFG_UNIDIR_HI] & cfg_r[`CFG_UNIDIR_LO];

    // Drivers enabled only inside a read data phase with select low
    assign sdio_oe = !cs_high && rd_r && (state_r == ST_DATA)
                     && !unidir_mode; // RULE_11 RULE_21
    assign sdo_oe  = !cs_high && rd_r && (state_r == ST_DATA)
                     && unidir_mode; // RULE_11 RULE_21

    // Shift order follows the live config, no update needed
    always @* begin
        if (lsb_first)
            sh_nxt = {sdio_lvl, sh_r[15:1]}; // RULE_17
        else
            sh_nxt = {sh_r[14:0], sdio_lvl}; // RULE_16
        rx_byte = lsb_first ? sh_nxt[15:8] : sh_nxt[7:0];
    end

    // Address sequencer walks every address, reserved ones included
    always @* begin
        if (lsb_first)
            addr_nxt = addr_r + `ADDR_ONE; // RULE_17 RULE_10
        else if (addr_r == `ADDR_ZERO)
            addr_nxt = `ADDR_UPDATE; // RULE_18
        else
            addr_nxt = addr_r - `ADDR_ONE; // RULE_16 RULE_10
        last_byte = stream_r ? (addr_r == `ADDR_UPDATE) // RULE_18
                             : (bytes_left_r == 2'h0); // RULE_03
    end

    // Readback source: instruction address or the stepped one
    always @* begin
        if (state_r == ST_INSTR)
            rd_addr = sh_nxt[`ADDR_W-1:0];
        else
            rd_addr = addr_nxt;
        rd_byte = `BYTE_ZERO;
        if (nv_busy) begin
            if (rd_addr == `ADDR_NV_STATUS)
                rd_byte = {7'h00, nv_busy}; // RULE_19
        end else if (rd_addr == `ADDR_CFG) begin
            rd_byte = cfg_r;
        end else if (rd_addr == `ADDR_BANK_SEL) begin
            rd_byte = {7'h00, bank_sel_r};
        end else if (rd_addr == `ADDR_UPDATE) begin
            rd_byte = `BYTE_ZERO; // RULE_07
        end else if (rd_addr < `REG_COUNT) begin
            if (bank_sel_r)
                rd_byte = act_mem[rd_addr[9:0]]; // RULE_12
            else
                rd_byte = buf_mem[rd_addr[9:0]]; // RULE_12
        end
    end

    always @* begin
        if (lsb_first)
            tx_nxt = {1'b0, tx_r[7:1]};
        else
            tx_nxt = {tx_r[6:0], 1'b0};
    end

    // Port sequencer on sampled SCLK rising edges
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r      <= ST_INSTR;
            bit_cnt_r    <= 4'h0;
            bytes_left_r <= 2'h0;
            stream_r     <= 1'b0;
            rd_r         <= 1'b0;
            addr_r       <= `ADDR_ZERO;
            sh_r         <= 16'h0000;
            tx_r         <= `BYTE_ZERO;
            sdio_out     <= 1'b0;
            sdo_out      <= 1'b0;
            wr_stb_r     <= 1'b0;
            wr_addr_r    <= `ADDR_ZERO;
            wr_data_r    <= `BYTE_ZERO;
        end else begin
            wr_stb_r <= 1'b0;
            if (cs_rise) begin
                // Stall keeps state on a boundary of an unfinished short cycle
                if (bit_cnt_r[2:0] != 3'h0 || state_r == ST_DONE
                    || (state_r == ST_DATA && stream_r)) begin // RULE_05
                    state_r   <= ST_INSTR; // RULE_06
                    bit_cnt_r <= 4'h0; // RULE_22
                    rd_r      <= 1'b0;
                    stream_r  <= 1'b0;
                    sh_r      <= 16'h0000;
                end
            end else if (sclk_rise && !cs_high) begin
                case (state_r)
                    ST_INSTR: begin
                        sh_r      <= sh_nxt;
                        bit_cnt_r <= bit_cnt_r + 4'h1; // RULE_22
                        if (bit_cnt_r == `INSTR_LAST) begin // RULE_01
                            state_r      <= ST_DATA;
                            bit_cnt_r    <= 4'h0;
                            rd_r         <= sh_nxt[`INSTR_RW_BIT]; // RULE_02
                            bytes_left_r <= sh_nxt[`INSTR_LEN_HI:
                                                   `INSTR_LEN_LO]; // RULE_03
                            stream_r     <= (sh_nxt[`INSTR_LEN_HI:
                                             `INSTR_LEN_LO] == `LEN_STREAM);
                            addr_r       <= sh_nxt[`ADDR_W-1:0]; // RULE_02
                            tx_r         <= rd_byte; // RULE_08
                            sdio_out     <= lsb_first ? rd_byte[0]
                                                      : rd_byte[7]; // RULE_09
                            sdo_out      <= lsb_first ? rd_byte[0]
                                                      : rd_byte[7];
                        end
                    end
                    ST_DATA: begin
                        sh_r      <= sh_nxt;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r[2:0] != `BYTE_LAST) begin
                            tx_r     <= tx_nxt;
                            // New bit lands on the sampled rise, five clocks after SCLK rises
                            sdio_out <= lsb_first ? tx_nxt[0]
                                                  : tx_nxt[7]; // RULE_09
                            sdo_out  <= lsb_first ? tx_nxt[0] : tx_nxt[7];
                        end else begin
                            bit_cnt_r <= 4'h0;
                            if (!rd_r) begin
                                wr_stb_r  <= 1'b1; // RULE_04
                                wr_addr_r <= addr_r;
                                wr_data_r <= rx_byte;
                            end
                            if (last_byte) begin
                                state_r <= ST_DONE; // RULE_08 RULE_18
                            end else begin
                                addr_r       <= addr_nxt;
                                bytes_left_r <= bytes_left_r - 2'h1;
                                tx_r         <= rd_byte; // RULE_08
                                sdio_out     <= lsb_first ? rd_byte[0]
                                                          : rd_byte[7];
                                sdo_out      <= lsb_first ? rd_byte[0]
                                                          : rd_byte[7];
                            end
                        end
                    end
                    ST_DONE: begin
                        bit_cnt_r <= bit_cnt_r;
                    end
                    default: begin
                        state_r <= ST_INSTR;
                    end
                endcase
            end
        end
    end

    // Register banks; writes land in the buffer, update copies all at once
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < `REG_COUNT; i = i + 1) begin
                buf_mem[i] <= `BYTE_ZERO;
                act_mem[i] <= `BYTE_ZERO;
            end
            cfg_r        <= `CFG_RESET;
            bank_sel_r   <= 1'b0;
            update_pulse <= 1'b0;
        end else begin
            update_pulse <= 1'b0;
            // Store transfer owns the registers; port writes dropped
            if (wr_stb_r && !nv_busy) begin // RULE_19
                if (wr_addr_r == `ADDR_UPDATE) begin
                    if (wr_data_r[`UPDATE_BIT]) begin // RULE_07
                        update_pulse <= 1'b1;
                        for (i = 0; i < `REG_COUNT; i = i + 1)
                            act_mem[i] <= buf_mem[i]; // RULE_07
                    end
                end else if (wr_addr_r < `REG_COUNT) begin
                    buf_mem[wr_addr_r[9:0]] <= wr_data_r; // RULE_04 RULE_10
                    if (wr_addr_r == `ADDR_CFG)
                        cfg_r <= wr_data_r; // RULE_15
                    if (wr_addr_r == `ADDR_BANK_SEL)
                        bank_sel_r <= wr_data_r[`BANK_SEL_BIT]; // RULE_12
                end
            end
        end
    end

    // Slave address answer for the two-wire form of the port
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            twi_addr_ack <= 1'b0;
        else
            twi_addr_ack <= !nv_busy; // RULE_20
    end
endmodule // serial_control_port

// >>> logic/spi_port_defines.vh
// Constants for the serial control port in its SPI form
// What this block does
// RULE_01 - Each cycle opens with a 16-bit instruction on the first 16 rising edges
// RULE_02 - Instruction: top bit read/write, two length bits, 13-bit start address
// RULE_03 - Length code 00/01/10 means 1/2/3 bytes, 11 means streaming
// RULE_04 - Write data sampled on rising SCLK and stored into the buffer bank
// RULE_05 - Short transfers may stall with chip select high on byte boundaries
// RULE_06 - Chip select rising off a byte boundary resets the port, drops partial
// RULE_07 - Update bit copies buffer bank to active bank at once, self-clears
// RULE_08 - Reads shift out 1 to 3 bytes, or stream up to the update register
// RULE_09 - Readback bits are stable at the falling SCLK edge
// RULE_10 - Address stepping never skips reserved addresses; writing zero there is fine
// RULE_11 - Readback on shared data pin unless both unidirectional bits are set
// RULE_12 - Bank select bit chooses buffer or active bank for readback
// RULE_13 - Host keeps upper three address bits zero; ten bits select registers
// RULE_14 - Host writes config with upper nibble mirroring lower nibble
// RULE_15 - MSB first by default; two config bits select LSB first at once
// RULE_16 - MSB first: address decrements after each data byte
// RULE_17 - LSB first: address increments after each data byte
// RULE_18 - Streaming stops at the update register; MSB order wraps zero to it
// RULE_19 - Store transfer running: refuse accesses except the busy flag
// RULE_20 - Two-wire mode: nack while store busy, ack once it is done
// RULE_21 - Both data outputs released while chip select is high
// RULE_22 - Bit and byte counters clear with chip select high except on stall; code clears only bit_cnt_r, bytes_left_r reloads per instruction
`ifndef SPI_PORT_DEFINES_VH
`define SPI_PORT_DEFINES_VH

`define INSTR_BITS      16
`define INSTR_LAST      4'hF
`define BYTE_LAST       3'h7
`define ADDR_W          13
`define INSTR_RW_BIT    15
`define INSTR_LEN_HI    14
`define INSTR_LEN_LO    13
`define LEN_STREAM      2'h3

`define REG_COUNT       563
`define ADDR_CFG        13'h000
`define ADDR_BANK_SEL   13'h004
`define ADDR_UPDATE     13'h232
`define ADDR_NV_STATUS  13'hB00
`define ADDR_ZERO       13'h000
`define ADDR_ONE        13'h001

`define CFG_RESET       8'h18
`define CFG_UNIDIR_HI   7
`define CFG_LSB_HI      6
`define CFG_LSB_LO      1
`define CFG_UNIDIR_LO   0
`define BANK_SEL_BIT    0
`define UPDATE_BIT      0
`define BYTE_ZERO       8'h00

`endif
